// *** frc_flash_regs.sv ***
// flash rewrite control and status register bank
`timescale 1ns/10ps
// Notes on behaviour
// - ready flag reads zero while busy
// - lock-bit, blank check commands also show busy
// - rewrite select bit enables software commands
// - lock disable bit makes lock bits ignored
// - stop bit stops, powers down, initialises
// - stop acts only with rewrite mode enabled
// - read-only program and erase error flags
// - error flags hold until clear status
// - main reset value depends on boot mode
// - write-enable bit gates config register writes
// - lock status flag: zero locked, one unlocked
// - data flash wait: one wait or processor
// - config bit selects erase-write mode
module frc_flash_regs (
   input  wire logic                     sys_clk,
   input  wire logic                     srst,
   input  wire logic                     userBootMode,
   input  wire frc_pkg::frc_axi_req_type axiReq,
   output frc_pkg::frc_axi_rsp_type      axiRsp,
   input  wire frc_pkg::frc_seq_type     seqStat,
   input  wire logic                     processor_wait_setting,
   output frc_pkg::frc_ctrl_type         flashCtrl,
   output logic                          irq
);
   // whole state of the register bank
   typedef struct packed {
      // main control fields
      logic                         rwSel;     // rewrite mode select
      logic                         lockDis;   // lock disable select
      logic                         stop;      // flash stop bit
      logic                         mainRsv4;  // reserved, kept as written
      logic                         mainRsv5;  // boot-mode reserved bit
      logic                         progErr;   // sticky program error
      logic                         eraseErr;  // sticky erase error
      logic                         armed;     // last bus write was a main write that cleared sel
      // aux, read mode and config fields
      logic                         cfgWe;     // config write enable
      logic                         auxRsv4;   // reserved, kept as written
      logic                         waitSel;   // data flash wait select
      logic [frc_pkg::RDM_BITS-1:0] rdMode;    // read mode control bits
      logic                         ewMode;    // erase-write mode select
      // interrupt and core control fields
      logic [frc_pkg::EV_N-1:0]     irqStat;   // sticky event bits
      logic [frc_pkg::EV_N-1:0]     irqMask;   // event enables
      frc_pkg::frc_ctrl_type        ctrlOut;   // registered core controls
   } frc_reg_state_type;

   frc_reg_state_type st_q;   // registered state
   frc_reg_state_type st_d;   // next state

   // register strobes from the bus front end
   logic                       wrPulse;
   logic [frc_pkg::ADDR_W-1:0] wrAddr;
   logic [frc_pkg::DATA_W-1:0] wrData;
   logic [3:0]                 wrStrb;
   logic                       wrHit;
   logic                       rdPulse;
   logic [frc_pkg::ADDR_W-1:0] rdAddr;
   logic [frc_pkg::DATA_W-1:0] rdData;
   logic                       rdHit;

   // byte addresses derived from the printed indices
   localparam logic [frc_pkg::ADDR_W-1:0] A_MAIN =
      frc_pkg::IDX_MAIN << frc_pkg::IDX_SHIFT;
   localparam logic [frc_pkg::ADDR_W-1:0] A_AUX =
      frc_pkg::IDX_AUX << frc_pkg::IDX_SHIFT;
   localparam logic [frc_pkg::ADDR_W-1:0] A_RDM =
      frc_pkg::IDX_RDM << frc_pkg::IDX_SHIFT;
   localparam logic [frc_pkg::ADDR_W-1:0] A_CFG =
      frc_pkg::IDX_CFG << frc_pkg::IDX_SHIFT;
   localparam logic [frc_pkg::ADDR_W-1:0] A_IST =
      frc_pkg::IDX_IST << frc_pkg::IDX_SHIFT;
   localparam logic [frc_pkg::ADDR_W-1:0] A_IMK =
      frc_pkg::IDX_IMK << frc_pkg::IDX_SHIFT;

   // decode and read-back helpers
   logic [frc_pkg::REG_W-1:0] wByte;    // low byte of write data
   logic                      wLane;    // low byte lane enabled
   logic [frc_pkg::REG_W-1:0] mainRd;   // main control as read
   logic [frc_pkg::REG_W-1:0] auxRd;    // aux control as read
   logic [frc_pkg::REG_W-1:0] regRd;    // selected register
   logic [frc_pkg::EV_N-1:0]  evNow;    // events seen this cycle
   logic                      wrMain;   // write strobes per register
   logic                      wrAux;
   logic                      wrRdm;
   logic                      wrCfg;
   logic                      wrImk;
   logic                      rdIst;    // read of the event register

   // bus front end
   frc_axil_slave u_slave (
      .sys_clk (sys_clk),
      .srst    (srst),
      .axiReq  (axiReq),
      .axiRsp  (axiRsp),
      .wrPulse (wrPulse),
      .wrAddr  (wrAddr),
      .wrData  (wrData),
      .wrStrb  (wrStrb),
      .wrHit   (wrHit),
      .rdPulse (rdPulse),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdHit   (rdHit)
   );

   // registers are one byte wide and live in the low lane
   assign wByte = wrData[frc_pkg::REG_W-1:0];
   assign wLane = wrStrb[0];

   // write address decode; a write with the low lane off changes nothing but armed
   always_comb begin
      wrMain = 1'b0;
      wrAux  = 1'b0;
      wrRdm  = 1'b0;
      wrCfg  = 1'b0;
      wrImk  = 1'b0;
      // mapped addresses answer okay, the rest with an error
      wrHit  = 1'b1;
      if (wrAddr == A_MAIN) begin
         wrMain = wrPulse && wLane;
      end else if (wrAddr == A_AUX) begin
         wrAux = wrPulse && wLane;
      end else if (wrAddr == A_RDM) begin
         wrRdm = wrPulse && wLane;
      end else if (wrAddr == A_CFG) begin
         wrCfg = wrPulse && wLane;
      end else if (wrAddr == A_IMK) begin
         wrImk = wrPulse && wLane;
      end else if (wrAddr == A_IST) begin
         wrHit = 1'b1;              // read-clear register, writes ignored
      end else begin
         wrHit = 1'b0;              // unmapped: slave answers with an error
      end
   end

   // main control as software sees it
   always_comb begin
      mainRd = frc_pkg::REG_ZERO;
      mainRd[frc_pkg::MAIN_READY]  = !seqStat.busy;
      mainRd[frc_pkg::MAIN_RWSEL]  = st_q.rwSel;
      mainRd[frc_pkg::MAIN_LOCKDS] = st_q.lockDis;
      mainRd[frc_pkg::MAIN_STOP]   = st_q.stop;
      mainRd[frc_pkg::MAIN_RSV4]   = st_q.mainRsv4;
      mainRd[frc_pkg::MAIN_RSV5]   = st_q.mainRsv5;
      // error flags sit in the top two bits, read-only
      mainRd[frc_pkg::MAIN_PERR]   = st_q.progErr;
      mainRd[frc_pkg::MAIN_EERR]   = st_q.eraseErr;
   end

   // aux control; undefined reserved bits return zero
   always_comb begin
      auxRd = frc_pkg::REG_ZERO;
      auxRd[frc_pkg::AUX_CFGWE] = st_q.cfgWe;
      auxRd[frc_pkg::AUX_RSV4]  = st_q.auxRsv4;
      // lock status comes straight from the sequencer
      auxRd[frc_pkg::AUX_LOCK]  = seqStat.unlocked;
      auxRd[frc_pkg::AUX_WAIT]  = st_q.waitSel;
   end

   // read address decode; narrow registers sit in the low byte
   always_comb begin
      regRd = frc_pkg::REG_ZERO;
      rdHit = 1'b1;
      rdIst = 1'b0;
      if (rdAddr == A_MAIN) begin
         regRd = mainRd;
      end else if (rdAddr == A_AUX) begin
         regRd = auxRd;
      end else if (rdAddr == A_RDM) begin
         regRd[frc_pkg::RDM_BITS-1:0] = st_q.rdMode;
      end else if (rdAddr == A_CFG) begin
         regRd[frc_pkg::CFG_EWMODE] = st_q.ewMode;
      end else if (rdAddr == A_IST) begin
         regRd[frc_pkg::EV_N-1:0] = st_q.irqStat;
         rdIst = rdPulse;
      end else if (rdAddr == A_IMK) begin
         regRd[frc_pkg::EV_N-1:0] = st_q.irqMask;
      end else begin
         rdHit = 1'b0;
      end
      // upper lanes always read zero
      rdData = {{(frc_pkg::DATA_W-frc_pkg::REG_W){1'b0}}, regRd};
   end

   // sequencer events that raise interrupt status bits
   always_comb begin
      evNow = '0;
      // an error event needs its done pulse in the same cycle
      evNow[frc_pkg::EV_PDONE] = seqStat.progDone;
      evNow[frc_pkg::EV_EDONE] = seqStat.eraseDone;
      evNow[frc_pkg::EV_PERR]  = seqStat.progDone && seqStat.progFail;
      evNow[frc_pkg::EV_EERR]  = seqStat.eraseDone && seqStat.eraseFail;
   end

   // next state of every register
   always_comb begin
      st_d = st_q;

      // main control write
      if (wrMain) begin
         // setting the select needs a write of 0 just before it
         if (wByte[frc_pkg::MAIN_RWSEL]) begin
            st_d.rwSel = st_q.rwSel || st_q.armed;
         end else begin
            st_d.rwSel = 1'b0;
         end
         st_d.armed    = !wByte[frc_pkg::MAIN_RWSEL];
         st_d.lockDis  = wByte[frc_pkg::MAIN_LOCKDS];
         st_d.stop     = wByte[frc_pkg::MAIN_STOP];
         st_d.mainRsv4 = wByte[frc_pkg::MAIN_RSV4];
         st_d.mainRsv5 = wByte[frc_pkg::MAIN_RSV5];
      end else if (wrPulse) begin
         // any other bus write breaks the back-to-back pair
         st_d.armed = 1'b0;
      end

      // aux control write
      if (wrAux) begin
         st_d.cfgWe   = wByte[frc_pkg::AUX_CFGWE];
         st_d.auxRsv4 = wByte[frc_pkg::AUX_RSV4];
         st_d.waitSel = wByte[frc_pkg::AUX_WAIT];
      end

      // read mode control write
      if (wrRdm) begin
         st_d.rdMode = wByte[frc_pkg::RDM_BITS-1:0];
      end

      // config write only when enabled and rewrite mode is on
      if (wrCfg && st_q.cfgWe && st_q.rwSel) begin
         st_d.ewMode = wByte[frc_pkg::CFG_EWMODE];
      end

      // leaving rewrite mode falls back to erase-write 0
      if (!st_d.rwSel) begin
         st_d.ewMode = 1'b0;
      end

      // interrupt mask write
      if (wrImk) begin
         st_d.irqMask = wByte[frc_pkg::EV_N-1:0];
      end

      // error flags: clear status first, a same-cycle error still sets
      if (seqStat.clearStatus) begin
         st_d.progErr  = 1'b0;
         st_d.eraseErr = 1'b0;
      end
      if (seqStat.progDone) begin
         st_d.progErr = seqStat.progFail || 
                        (st_q.progErr && !seqStat.clearStatus);
      end
      if (seqStat.eraseDone) begin
         st_d.eraseErr = seqStat.eraseFail ||
                         (st_q.eraseErr && !seqStat.clearStatus);
      end

      // event bits: a read clears, a new event in that cycle survives
      st_d.irqStat = (rdIst ? '0 : st_q.irqStat) | evNow;

      // core controls leave from flops
      st_d.ctrlOut               = '0;
      st_d.ctrlOut.rewriteEnable = st_d.rwSel;
      st_d.ctrlOut.lockDisable   = st_d.lockDis;
      // the stop bit is stored as written but acts only in rewrite mode
      st_d.ctrlOut.flashStop     = st_d.stop && st_d.rwSel;
      st_d.ctrlOut.eraseWrite1   = st_d.ewMode;
      st_d.ctrlOut.readMode      = st_d.rdMode;
      // 0 forces one wait, 1 follows the processor setting
      st_d.ctrlOut.dataFlashWait1 =
         !st_d.waitSel || processor_wait_setting;
   end

   // state register; main control bit 5 follows the boot mode at reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q          <= '0;
         // bit 5 alone takes its reset value from the boot mode
         st_q.mainRsv5 <= userBootMode;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs to the flash core; each leaves a flop, so no decode glitch
   assign flashCtrl.rewriteEnable  = st_q.ctrlOut.rewriteEnable;
   assign flashCtrl.lockDisable    = st_q.ctrlOut.lockDisable;
   assign flashCtrl.flashStop      = st_q.ctrlOut.flashStop;
   assign flashCtrl.eraseWrite1    = st_q.ctrlOut.eraseWrite1;
   assign flashCtrl.dataFlashWait1 = st_q.ctrlOut.dataFlashWait1;
   assign flashCtrl.readMode       = st_q.ctrlOut.readMode;

   // level interrupt from any unmasked event
   assign irq = |(st_q.irqStat & st_q.irqMask);
endmodule : frc_flash_regs

// *** frc_pkg.sv ***
// shared constants and carrier types for the flash rewrite control bank
package frc_pkg;
   localparam int ADDR_W = 12;                 // axi byte address width
   localparam int DATA_W = 32;                 // axi data width
   localparam int REG_W  = 8;                  // width of each register
   // printed register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_MAIN = 12'h220;
   localparam logic [ADDR_W-1:0] IDX_AUX  = 12'h221;
   localparam logic [ADDR_W-1:0] IDX_RDM  = 12'h222;
   localparam logic [ADDR_W-1:0] IDX_CFG  = 12'h223;
   localparam logic [ADDR_W-1:0] IDX_IST  = 12'h224;
   localparam logic [ADDR_W-1:0] IDX_IMK  = 12'h225;
   localparam int IDX_SHIFT = 2;               // index to byte address
   // main control bit positions
   localparam int MAIN_READY  = 0;
   localparam int MAIN_RWSEL  = 1;
   localparam int MAIN_LOCKDS = 2;
   localparam int MAIN_STOP   = 3;
   localparam int MAIN_RSV4   = 4;
   localparam int MAIN_RSV5   = 5;
   localparam int MAIN_PERR   = 6;
   localparam int MAIN_EERR   = 7;
   // aux control bit positions
   localparam int AUX_CFGWE = 1;
   localparam int AUX_RSV4  = 4;
   localparam int AUX_LOCK  = 6;
   localparam int AUX_WAIT  = 7;
   // read mode control: four stored bits, upper nibble reads zero
   localparam int RDM_BITS   = 4;
   localparam int RDM_LOWCUR = 3;
   // rewrite mode config bit position
   localparam int CFG_EWMODE = 0;
   // interrupt event bit positions
   localparam int EV_N     = 4;
   localparam int EV_PDONE = 0;
   localparam int EV_EDONE = 1;
   localparam int EV_PERR  = 2;
   localparam int EV_EERR  = 3;
   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
   localparam logic [REG_W-1:0]  REG_ZERO  = 8'h00;

   // master to slave signals
   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } frc_axi_req_type;

   // slave to master signals
   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } frc_axi_rsp_type;

   // status coming from the flash command sequencer
   typedef struct packed {
      logic busy;        // any program, erase or lock-bit command running
      logic progDone;    // pulse: program finished
      logic progFail;    // with progDone: it ended in error
      logic eraseDone;   // pulse: erase finished
      logic eraseFail;   // with eraseDone: it ended in error
      logic clearStatus; // pulse: clear status command executed
      logic unlocked;    // lock status of the addressed block
   } frc_seq_type;

   // controls going to the flash core
   typedef struct packed {
      logic       rewriteEnable;   // software commands accepted
      logic       lockDisable;     // ignore block lock bits
      logic       flashStop;       // stop, low power, initialise
      logic       eraseWrite1;     // 0: erase-write 0, 1: erase-write 1
      logic       dataFlashWait1;  // data flash access uses one wait
      logic [RDM_BITS-1:0] readMode;
   } frc_ctrl_type;
endpackage : frc_pkg

// *** frc_axil_slave.sv ***
// axi4-lite slave front end: turns bus transfers into register strobes
`timescale 1ns/10ps
module frc_axil_slave (
   input  wire logic                             sys_clk,
   input  wire logic                             srst,
   input  wire frc_pkg::frc_axi_req_type         axiReq,
   output frc_pkg::frc_axi_rsp_type              axiRsp,
   output logic                                  wrPulse,
   output logic [frc_pkg::ADDR_W-1:0]            wrAddr,
   output logic [frc_pkg::DATA_W-1:0]            wrData,
   output logic [3:0]                            wrStrb,
   input  wire logic                             wrHit,
   output logic                                  rdPulse,
   output logic [frc_pkg::ADDR_W-1:0]            rdAddr,
   input  wire logic [frc_pkg::DATA_W-1:0]       rdData,
   input  wire logic                             rdHit
);
   // whole state of the front end
   typedef struct packed {
      logic                       awHeld;  // write address captured
      logic [frc_pkg::ADDR_W-1:0] awAddr;
      logic                       wHeld;   // write data captured
      logic [frc_pkg::DATA_W-1:0] wData;
      logic [3:0]                 wStrb;
      logic                       bValid;
      logic [1:0]                 bResp;
      logic                       rValid;
      logic [frc_pkg::DATA_W-1:0] rData;
      logic [1:0]                 rResp;
   } frc_slv_state_type;

   frc_slv_state_type st_q;   // registered state
   frc_slv_state_type st_d;   // next state
   logic awAcc;               // address handshake this cycle
   logic wAcc;                // data handshake this cycle
   logic arAcc;               // read address handshake this cycle

   // ready terms: hold off new writes until the response has gone
   assign axiRsp.awready = !st_q.awHeld && !st_q.bValid;
   assign axiRsp.wready  = !st_q.wHeld && !st_q.bValid;
   assign axiRsp.arready = !st_q.rValid;
   assign axiRsp.bvalid  = st_q.bValid;
   assign axiRsp.bresp   = st_q.bResp;
   assign axiRsp.rvalid  = st_q.rValid;
   assign axiRsp.rdata   = st_q.rData;
   assign axiRsp.rresp   = st_q.rResp;
   assign awAcc = axiReq.awvalid && axiRsp.awready;
   assign wAcc  = axiReq.wvalid && axiRsp.wready;
   assign arAcc = axiReq.arvalid && axiRsp.arready;

   // write strobe once both halves are held; read strobe at handshake
   assign wrPulse = st_q.awHeld && st_q.wHeld && !st_q.bValid;
   assign wrAddr  = st_q.awAddr;
   assign wrData  = st_q.wData;
   assign wrStrb  = st_q.wStrb;
   assign rdPulse = arAcc;
   assign rdAddr  = axiReq.araddr;

   // next state
   always_comb begin
      st_d = st_q;
      if (awAcc) begin
         st_d.awHeld = 1'b1;
         st_d.awAddr = axiReq.awaddr;
      end
      if (wAcc) begin
         st_d.wHeld = 1'b1;
         st_d.wData = axiReq.wdata;
         st_d.wStrb = axiReq.wstrb;
      end
      // the register write happens in this cycle, answer next
      if (wrPulse) begin
         st_d.awHeld = 1'b0;
         st_d.wHeld  = 1'b0;
         st_d.bValid = 1'b1;
         st_d.bResp  = wrHit ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
      end else if (st_q.bValid && axiReq.bready) begin
         st_d.bValid = 1'b0;
      end
      // read data is sampled at the handshake so side effects line up
      if (arAcc) begin
         st_d.rValid = 1'b1;
         st_d.rData  = rdHit ? rdData : frc_pkg::DATA_ZERO;
         st_d.rResp  = rdHit ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
      end else if (st_q.rValid && axiReq.rready) begin
         st_d.rValid = 1'b0;
      end
   end

   // state register with synchronous reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule : frc_axil_slave

// *** frc_flash_regs_assertions.sv ***
// port-level assertion checker for the flash rewrite control bank
`timescale 1ns/10ps
module frc_flash_regs_assertions (
   input wire logic                     sys_clk,
   input wire logic                     srst,
   input wire logic                     userBootMode,
   input wire frc_pkg::frc_axi_req_type axiReq,
   input wire frc_pkg::frc_axi_rsp_type axiRsp,
   input wire frc_pkg::frc_seq_type     seqStat,
   input wire logic                     processor_wait_setting,
   input wire frc_pkg::frc_ctrl_type    flashCtrl,
   input wire logic                     irq
);
   // byte addresses: main control and the last mapped register
   localparam logic [11:0] A_MAIN = frc_pkg::IDX_MAIN << frc_pkg::IDX_SHIFT;
   localparam logic [11:0] A_LAST = frc_pkg::IDX_IMK << frc_pkg::IDX_SHIFT;
   logic arHit;   // read address taken at this edge
   logic wrBoth;  // both write halves taken at one edge
   assign arHit  = axiReq.arvalid && axiRsp.arready;
   assign wrBoth = axiReq.awvalid && axiRsp.awready
                   && axiReq.wvalid && axiRsp.wready;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // busy held over two edges, so the check also passes if the ready bit lags busy by one cycle
   a_ready_busy: assert property (
      seqStat.busy && $past(seqStat.busy) && arHit && axiReq.araddr == A_MAIN
      |=> !axiRsp.rdata[frc_pkg::MAIN_READY]) else $error("ready while busy");
   a_stop_gated: assert property (
      flashCtrl.flashStop |-> flashCtrl.rewriteEnable)
      else $error("stop active without rewrite mode");
   a_wait_follow: assert property (
      processor_wait_setting |=> flashCtrl.dataFlashWait1)
      else $error("data flash wait ignores processor setting");
   a_config_cleared: assert property (
      !flashCtrl.rewriteEnable |=> !flashCtrl.eraseWrite1)
      else $error("erase-write mode kept without rewrite mode");
   a_write_latency: assert property (wrBoth |-> ##2 axiRsp.bvalid)
      else $error("write response not two cycles after transfer");
   a_read_latency: assert property (arHit |=> axiRsp.rvalid)
      else $error("read data not one cycle after address");
   a_bresp_stands: assert property (axiRsp.bvalid && !axiReq.bready
      |=> axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("bresp dropped");
   a_rdata_stands: assert property (axiRsp.rvalid && !axiReq.rready
      |=> axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("rdata dropped");
   a_unmapped_err: assert property (arHit && axiReq.araddr > A_LAST
      |=> axiRsp.rresp == frc_pkg::RESP_SLVERR
          && axiRsp.rdata == frc_pkg::DATA_ZERO) else $error("unmapped read");
   // main scenarios reached
   c_write: cover property (axiRsp.bvalid && axiReq.bready);
   c_read: cover property (axiRsp.rvalid && axiReq.rready);
   c_irq: cover property ($rose(irq));
endmodule : frc_flash_regs_assertions

bind frc_flash_regs frc_flash_regs_assertions frc_flash_regs_assertions_i (
   .sys_clk(sys_clk), .srst(srst), .userBootMode(userBootMode),
   .axiReq(axiReq), .axiRsp(axiRsp), .seqStat(seqStat),
   .processor_wait_setting(processor_wait_setting),
   .flashCtrl(flashCtrl), .irq(irq));

// *** frc_flash_regs_tb.sv ***
// self-checking bench for the flash rewrite control register bank
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
   $display("BAD %0t got %h want %h", $time, a, e); end end
module frc_flash_regs_tb;
   logic                     sys_clk;
   logic                     srst;
   logic                     userBootMode;
   frc_pkg::frc_axi_req_type axiReq;
   frc_pkg::frc_axi_rsp_type axiRsp;
   frc_pkg::frc_seq_type     seqStat;      // held at unlocked between pulses
   logic                     processor_wait_setting;
   frc_pkg::frc_ctrl_type    flashCtrl;
   logic                     irq;
   int                       n_fail = 0;
   int                       check_count = 0;
   logic [7:0]               d;            // read data
   logic [1:0]               r;            // last read or write response
   // index, written, read back, response, then {flashCtrl, irq}
   logic [39:0] rows [6] = '{
      {frc_pkg::IDX_RDM,  8'hFF, 8'h0F, 2'h0, 10'h03E},
      {frc_pkg::IDX_MAIN, 8'h04, 8'h05, 2'h0, 10'h13E},
      {frc_pkg::IDX_AUX,  8'h82, 8'hC2, 2'h0, 10'h11E},
      {12'h230,           8'hAA, 8'h00, 2'h2, 10'h11E},
      {frc_pkg::IDX_RDM,  8'h00, 8'h00, 2'h0, 10'h100},
      {frc_pkg::IDX_MAIN, 8'h00, 8'h01, 2'h0, 10'h000}};

   frc_flash_regs frc_flash_regs_i (.sys_clk(sys_clk), .srst(srst),
      .userBootMode(userBootMode), .axiReq(axiReq), .axiRsp(axiRsp),
      .seqStat(seqStat), .processor_wait_setting(processor_wait_setting),
      .flashCtrl(flashCtrl), .irq(irq));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test

   // five edges of reset; returns just after the first edge out of it
   task automatic rst(input logic ubm);
      userBootMode <= ubm;
      srst <= 1'b1;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
   endtask : rst

   // one-cycle sequencer event
   task automatic pulse(input logic [6:0] s);
      seqStat <= s;
      @(posedge sys_clk);
      seqStat <= 7'h01;
   endtask : pulse

   // outputs judged at the falling edge, where they have settled
   task automatic ctl(input logic [9:0] e);
      @(negedge sys_clk);
      `CHK({flashCtrl, irq}, e)
      @(posedge sys_clk);
   endtask : ctl

   // ready seen at the falling edge means the item moves at the next rise
   task automatic wr(input logic [11:0] i, input logic [7:0] v,
                     input logic [1:0] er);
      logic aw, w, b, bv, ah, wh;
      int   n;
      aw = 1'b1; w = 1'b1; b = 1'b0; n = 0;
      axiReq.awvalid <= 1'b1; axiReq.awaddr <= i << 2; axiReq.wvalid <= 1'b1;
      axiReq.wdata <= {24'h000000, v}; axiReq.wstrb <= 4'hF;
      // bready rises once bvalid shows, so the response must stand a cycle
      while (!b && n < 50) begin
         @(negedge sys_clk);
         ah = aw && axiRsp.awready;
         wh = w && axiRsp.wready;
         bv = axiRsp.bvalid;
         b = bv && axiReq.bready;
         r = axiRsp.bresp;
         @(posedge sys_clk);
         if (ah) begin aw = 1'b0; axiReq.awvalid <= 1'b0; end
         if (wh) begin w = 1'b0; axiReq.wvalid <= 1'b0; end
         axiReq.bready <= bv && !b;
         n++;
      end
      `CHK({b, r}, {1'b1, er})
   endtask : wr

   task automatic rd(input logic [11:0] i);
      logic ar, ah, g, rv;
      int   n;
      ar = 1'b1; g = 1'b0; n = 0;
      axiReq.arvalid <= 1'b1; axiReq.araddr <= i << 2;
      // rready rises once rvalid shows, so the data must stand a cycle
      while (!g && n < 50) begin
         @(negedge sys_clk);
         ah = ar && axiRsp.arready;
         rv = axiRsp.rvalid;
         g = rv && axiReq.rready;
         d = axiRsp.rdata[7:0];
         r = axiRsp.rresp;
         @(posedge sys_clk);
         if (ah) begin ar = 1'b0; axiReq.arvalid <= 1'b0; end
         axiReq.rready <= rv && !g;
         n++;
      end
      if (!g) n_fail++;
   endtask : rd

   // read one register and compare with an OKAY answer
   task automatic chk(input logic [11:0] i, input logic [7:0] e);
      rd(i);
      `CHK({r, d}, {frc_pkg::RESP_OKAY, e})
   endtask : chk

   initial begin
      #400000;
      n_fail++;
      finish_test();
   end

   initial begin
      axiReq = '0; seqStat = 7'h01; processor_wait_setting = 1'b0;
      userBootMode = 1'b0; srst = 1'b1;
      rst(1'b0);
      chk(frc_pkg::IDX_MAIN, 8'h01);
      chk(frc_pkg::IDX_AUX, 8'h40);
      ctl(10'h020);
      $display("reset values done");
      foreach (rows[k]) begin
         wr(rows[k][39:28], rows[k][27:20], rows[k][11:10]);
         ctl(rows[k][9:0]);
         rd(rows[k][39:28]);
         `CHK({r, d}, {rows[k][11:10], rows[k][19:12]})
      end
      processor_wait_setting <= 1'b1;
      @(posedge sys_clk);
      ctl(10'h020);
      processor_wait_setting <= 1'b0;
      $display("register rows done");
      // a lone write of one is refused; zero then one is taken
      wr(frc_pkg::IDX_RDM, 8'h00, 2'h0);
      wr(frc_pkg::IDX_MAIN, 8'h02, 2'h0);
      chk(frc_pkg::IDX_MAIN, 8'h01);
      wr(frc_pkg::IDX_MAIN, 8'h00, 2'h0);
      wr(frc_pkg::IDX_MAIN, 8'h02, 2'h0);
      chk(frc_pkg::IDX_MAIN, 8'h03);
      wr(frc_pkg::IDX_CFG, 8'h01, 2'h0);
      ctl(10'h240);
      wr(frc_pkg::IDX_AUX, 8'h80, 2'h0);
      wr(frc_pkg::IDX_CFG, 8'h00, 2'h0);
      chk(frc_pkg::IDX_CFG, 8'h01);
      wr(frc_pkg::IDX_MAIN, 8'h0A, 2'h0);
      ctl(10'h2C0);
      wr(frc_pkg::IDX_MAIN, 8'h08, 2'h0);
      ctl(10'h000);
      chk(frc_pkg::IDX_MAIN, 8'h09);
      $display("mode control done");
      wr(frc_pkg::IDX_IMK, 8'h0F, 2'h0);
      pulse(7'h31);
      ctl(10'h001);
      chk(frc_pkg::IDX_MAIN, 8'h49);
      chk(frc_pkg::IDX_IST, 8'h05);
      ctl(10'h000);
      pulse(7'h0D);
      chk(frc_pkg::IDX_MAIN, 8'hC9);
      pulse(7'h03);
      chk(frc_pkg::IDX_MAIN, 8'h09);
      chk(frc_pkg::IDX_IST, 8'h0A);
      seqStat <= 7'h41;
      @(posedge sys_clk);
      chk(frc_pkg::IDX_MAIN, 8'h08);
      seqStat <= 7'h01;
      wr(frc_pkg::IDX_IMK, 8'h00, 2'h0);
      pulse(7'h21);
      ctl(10'h000);
      chk(frc_pkg::IDX_IST, 8'h01);
      $display("events done");
      rst(1'b1);
      chk(frc_pkg::IDX_MAIN, 8'h21);
      $display("boot reset done");
      finish_test();
   end
endmodule : frc_flash_regs_tb
